// [msd_decoder.sv]
`timescale 1ns/10ps
`include "msd_cfg.svh"
// How it works
// - register file addresses are twelve bits, covering 4096 bytes
// - addresses F00h to FFFh go to the control register block, not RAM
// - reserved control reads return whatever the control block gives
// - RAM starts at 000h; its size is a parameter from 256 bytes to 1KB
// - between RAM top and F00h reads give a fill byte, writes dropped
// - 64KB program space, flash from zero, 1KB to 8KB by parameter
// - program reads beyond flash return FFh; writes there are dropped
// - program addresses are classed into option, reset, watchdog, trap, interrupt, oscillator and code regions
// - data memory accesses are answered but backed by no storage
// - page select bit 7 enables the information area overlay
// - with overlay on, reads FE00h to FF7Fh come from the information area, except the part identifier bytes
// - with overlay on, writes to FE00h to FF7Fh are dropped
// - part identifier at FE40 to FE53 is a fixed twenty byte string
module msd_decoder #(
  parameter logic [12:0] RAM_SIZE = `MSD_RAM_SIZE,
  parameter logic [16:0] FLASH_SIZE = `MSD_FLASH_SIZE,
  // arbitrary identifier text, left-justified and padded with F
  parameter logic [159:0] PART_ID = "MSDPART0FFFFFFFFFFFF"
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // register file access from the core
  input wire logic [11:0] rf_addr_in,
  input wire logic rf_rd_in,
  input wire logic rf_wr_in,
  input wire logic [7:0] rf_wdata_in,
  output logic [7:0] rf_rdata_out,
  output logic rf_ack_out,
  // program memory access from the core
  input wire logic [15:0] pm_addr_in,
  input wire logic pm_rd_in,
  input wire logic pm_wr_in,
  input wire logic [7:0] pm_wdata_in,
  output logic [7:0] pm_rdata_out,
  output logic pm_ack_out,
  output msd_pkg::msd_pm_region_e pm_region_out,
  // data memory access from the core
  input wire logic ds_rd_in,
  input wire logic ds_wr_in,
  output logic [7:0] ds_rdata_out,
  output logic ds_ack_out,
  // flash page select value
  input wire logic [7:0] page_sel_in,
  // register file RAM
  output logic [11:0] ram_addr_out,
  output logic ram_re_out,
  output logic ram_we_out,
  output logic [7:0] ram_wdata_out,
  input wire logic [7:0] ram_rdata_in,
  // control register block
  output logic [7:0] ctrl_addr_out,
  output logic ctrl_re_out,
  output logic ctrl_we_out,
  output logic [7:0] ctrl_wdata_out,
  input wire logic [7:0] ctrl_rdata_in,
  // program flash
  output logic [15:0] flash_addr_out,
  output logic flash_re_out,
  output logic flash_we_out,
  output logic [7:0] flash_wdata_out,
  input wire logic [7:0] flash_rdata_in,
  // information area storage
  output logic [6:0] info_addr_out,
  output logic info_re_out,
  input wire logic [7:0] info_rdata_in
);
  import msd_pkg::*;

  // ----------------------------------------
  // part identifier table
  // ----------------------------------------
  logic [7:0] part_rom [`MSD_PARTID_LEN];
  genvar gi;
  // one byte per entry, first character at the lowest address
  generate
    for (gi = 0; gi < `MSD_PARTID_LEN; gi++) begin : g_part
      assign part_rom[gi] = PART_ID[159 - 8 * gi -: 8];
    end
  endgenerate

  // ----------------------------------------
  // register file decode
  // ----------------------------------------
  wire rf_req = rf_rd_in | rf_wr_in;
  wire rf_is_ctrl = (rf_addr_in >= `MSD_CTRL_BASE);
  wire rf_is_ram = ({1'b0, rf_addr_in} < RAM_SIZE);
  wire rf_ram_rd = rf_rd_in & rf_is_ram;
  wire rf_ram_wr = rf_wr_in & rf_is_ram;
  wire rf_ctrl_rd = rf_rd_in & rf_is_ctrl;
  wire rf_ctrl_wr = rf_wr_in & rf_is_ctrl;
  wire msd_rf_src_e rf_src_next = rf_is_ctrl ? MSD_RF_CTRL : (rf_is_ram ? MSD_RF_RAM : MSD_RF_NONE);

  // ----------------------------------------
  // program memory decode
  // ----------------------------------------
  wire info_on = page_sel_in[`MSD_INFO_SEL_BIT];
  wire pm_req = pm_rd_in | pm_wr_in;
  wire pm_in_window = (pm_addr_in >= `MSD_INFO_BASE) && (pm_addr_in <= `MSD_INFO_LAST);
  wire pm_overlay = info_on & pm_in_window;
  wire pm_in_part = (pm_addr_in >= `MSD_PARTID_BASE) && (pm_addr_in <= `MSD_PARTID_LAST);
  wire pm_in_flash = ({1'b0, pm_addr_in} < FLASH_SIZE);
  wire pm_flash_rd = pm_rd_in & pm_in_flash & ~pm_overlay;
  wire pm_flash_wr = pm_wr_in & pm_in_flash & ~pm_overlay;
  wire pm_info_rd = pm_rd_in & pm_overlay & ~pm_in_part;
  wire [15:0] pm_info_off = pm_addr_in - `MSD_INFO_BASE;
  wire [15:0] pm_part_off = pm_addr_in - `MSD_PARTID_BASE;
  wire msd_pm_src_e pm_src_next = pm_overlay ? (pm_in_part ? MSD_PM_PARTID : MSD_PM_INFO)
                                             : (pm_in_flash ? MSD_PM_FLASH : MSD_PM_FILL);

  // vector layout classification
  wire msd_pm_region_e region_next =
    (pm_addr_in < `MSD_VEC_RESET) ? MSD_REG_OPTION :
    (pm_addr_in < `MSD_VEC_WDT) ? MSD_REG_RESET :
    (pm_addr_in < `MSD_VEC_TRAP) ? MSD_REG_WDT :
    (pm_addr_in < `MSD_VEC_IRQ) ? MSD_REG_TRAP :
    (pm_addr_in < `MSD_VEC_OSC) ? MSD_REG_IRQ :
    (pm_addr_in < `MSD_CODE_BASE) ? MSD_REG_OSC : MSD_REG_CODE;

  // ----------------------------------------
  // first stage: drive the memories
  // ----------------------------------------
  msd_rf_src_e rf_src_reg;
  msd_pm_src_e pm_src_reg;
  logic rf_req_reg;
  logic pm_req_reg;
  logic ds_req_reg;
  logic [4:0] part_idx_reg;

  // strobes to the memories and the request flag of each bus
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      ram_re_out <= 1'b0;
      ram_we_out <= 1'b0;
      ctrl_re_out <= 1'b0;
      ctrl_we_out <= 1'b0;
      flash_re_out <= 1'b0;
      flash_we_out <= 1'b0;
      info_re_out <= 1'b0;
      rf_req_reg <= 1'b0;
      pm_req_reg <= 1'b0;
      ds_req_reg <= 1'b0;
    end else begin
      ram_re_out <= rf_ram_rd;
      ram_we_out <= rf_ram_wr;
      ctrl_re_out <= rf_ctrl_rd;
      ctrl_we_out <= rf_ctrl_wr;
      flash_re_out <= pm_flash_rd;
      flash_we_out <= pm_flash_wr;
      info_re_out <= pm_info_rd;
      rf_req_reg <= rf_req;
      pm_req_reg <= pm_req;
      ds_req_reg <= ds_rd_in | ds_wr_in;
    end
  end

  // addresses, write data and read sources
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      ram_addr_out <= 12'h000;
      ram_wdata_out <= 8'h00;
      ctrl_addr_out <= 8'h00;
      ctrl_wdata_out <= 8'h00;
      flash_addr_out <= 16'h0000;
      flash_wdata_out <= 8'h00;
      info_addr_out <= 7'h00;
      part_idx_reg <= 5'h00;
      rf_src_reg <= MSD_RF_NONE;
      pm_src_reg <= MSD_PM_FILL;
    end else begin
      ram_addr_out <= rf_addr_in - `MSD_RAM_BASE;
      ram_wdata_out <= rf_wdata_in;
      ctrl_addr_out <= rf_addr_in[7:0];
      ctrl_wdata_out <= rf_wdata_in;
      flash_addr_out <= pm_addr_in;
      flash_wdata_out <= pm_wdata_in;
      info_addr_out <= pm_info_off[6:0];
      part_idx_reg <= pm_part_off[4:0];
      rf_src_reg <= rf_src_next;
      pm_src_reg <= pm_src_next;
    end
  end

  // ----------------------------------------
  // second stage: return read data
  // ----------------------------------------
  wire [7:0] rf_rdata_next = (rf_src_reg == MSD_RF_RAM) ? ram_rdata_in :
                             (rf_src_reg == MSD_RF_CTRL) ? ctrl_rdata_in : `MSD_UNDEF_BYTE;
  wire [7:0] pm_rdata_next = (pm_src_reg == MSD_PM_FLASH) ? flash_rdata_in :
                             (pm_src_reg == MSD_PM_INFO) ? info_rdata_in :
                             (pm_src_reg == MSD_PM_PARTID) ? part_rom[part_idx_reg] : `MSD_UNIMP_BYTE;

  // answers to the core, one cycle after the memory strobe
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      rf_rdata_out <= 8'h00;
      rf_ack_out <= 1'b0;
      pm_rdata_out <= 8'h00;
      pm_ack_out <= 1'b0;
      ds_rdata_out <= 8'h00;
      ds_ack_out <= 1'b0;
    end else begin
      rf_rdata_out <= rf_rdata_next;
      rf_ack_out <= rf_req_reg;
      pm_rdata_out <= pm_rdata_next;
      pm_ack_out <= pm_req_reg;
      ds_rdata_out <= `MSD_UNDEF_BYTE;
      ds_ack_out <= ds_req_reg;
    end
  end

  // region of each program access, held until the next one
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      pm_region_out <= MSD_REG_OPTION;
    end else if (pm_req) begin
      pm_region_out <= region_next;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  a_ctrl_range_sel: assert property (rf_rd_in && rf_addr_in >= 12'hf00 |=> ctrl_re_out && !ram_re_out)
    else $error("control range read not routed to control block");
  a_ram_write_sel: assert property (rf_wr_in && {1'b0, rf_addr_in} < RAM_SIZE |=> ram_we_out && !ctrl_we_out)
    else $error("ram write not forwarded");
  a_gap_write_drop: assert property (rf_wr_in && {1'b0, rf_addr_in} >= RAM_SIZE && rf_addr_in < 12'hf00
                                     |=> !ram_we_out && !ctrl_we_out)
    else $error("write in unmapped register gap reached a memory");
  a_unimp_read_ff: assert property (pm_rd_in && {1'b0, pm_addr_in} >= FLASH_SIZE && !pm_overlay
                                    |=> ##1 pm_ack_out && pm_rdata_out == 8'hff)
    else $error("unimplemented program read did not return ff");
  a_unimp_write_drop: assert property (pm_wr_in && {1'b0, pm_addr_in} >= FLASH_SIZE |=> !flash_we_out)
    else $error("unimplemented program write reached flash");
  a_overlay_read: assert property (pm_rd_in && page_sel_in[7] && pm_addr_in >= 16'hfe00 && pm_addr_in <= 16'hff7f
                                   |=> !flash_re_out)
    else $error("overlay read went to flash");
  a_overlay_ro: assert property (pm_wr_in && page_sel_in[7] && pm_addr_in >= 16'hfe00 && pm_addr_in <= 16'hff7f
                                 |=> !flash_we_out)
    else $error("write altered information area");
  a_part_id: assert property (pm_rd_in && page_sel_in[7] && pm_addr_in == 16'hfe40
                              |=> ##1 pm_rdata_out == PART_ID[159:152])
    else $error("part identifier first byte wrong");
  a_reset_vec: assert property (pm_rd_in && pm_addr_in == 16'h0002 |=> pm_region_out == MSD_REG_RESET)
    else $error("reset vector region wrong");
  a_ds_empty: assert property (ds_rd_in |=> ##1 ds_ack_out && ds_rdata_out == 8'h00)
    else $error("data space answer wrong");
  a_overlay_off: assert property (pm_rd_in && !page_sel_in[7] && pm_addr_in == 16'hfe00
                                  |=> !info_re_out)
    else $error("information area read while overlay off");

  // register file routing in both directions
  a_ram_read_sel: assert property (rf_rd_in && {1'b0, rf_addr_in} < RAM_SIZE |=> ram_re_out && !ctrl_re_out)
    else $error("ram read not forwarded");
  a_ctrl_write_sel: assert property (rf_wr_in && rf_addr_in >= `MSD_CTRL_BASE |=> ctrl_we_out && !ram_we_out)
    else $error("control range write not routed to control block");
  a_gap_read_fill: assert property (rf_rd_in && {1'b0, rf_addr_in} >= RAM_SIZE && rf_addr_in < `MSD_CTRL_BASE
                                    |=> ##1 rf_ack_out && rf_rdata_out == `MSD_UNDEF_BYTE)
    else $error("read in unmapped register gap returned wrong byte");
  a_rf_answer: assert property (rf_rd_in || rf_wr_in |=> ##1 rf_ack_out)
    else $error("register file access not answered");

  // program memory routing and overlay
  a_flash_read_sel: assert property (pm_rd_in && {1'b0, pm_addr_in} < FLASH_SIZE && !page_sel_in[7]
                                     |=> flash_re_out && flash_addr_out == $past(pm_addr_in))
    else $error("flash read not forwarded");
  a_pm_answer: assert property (pm_rd_in || pm_wr_in |=> ##1 pm_ack_out)
    else $error("program access not answered");
  a_part_id_last: assert property (pm_rd_in && page_sel_in[7] && pm_addr_in == `MSD_PARTID_LAST
                                   |=> ##1 pm_rdata_out == PART_ID[7:0])
    else $error("part identifier last byte wrong");
  a_info_addr: assert property (pm_rd_in && page_sel_in[7] && pm_addr_in == 16'hfe60
                                |=> info_re_out && info_addr_out == 7'h60)
    else $error("information area read misaddressed");
  a_overlay_off_ff: assert property (pm_rd_in && !page_sel_in[7] && pm_addr_in >= `MSD_INFO_BASE
                                     && pm_addr_in <= `MSD_INFO_LAST && {1'b0, pm_addr_in} >= FLASH_SIZE
                                     |=> ##1 pm_rdata_out == `MSD_UNIMP_BYTE)
    else $error("window read with overlay off did not return ff");

  // vector layout classes
  a_trap_vec: assert property (pm_rd_in && pm_addr_in == `MSD_VEC_TRAP |=> pm_region_out == MSD_REG_TRAP)
    else $error("trap vector region wrong");
  a_code_base: assert property (pm_rd_in && pm_addr_in == `MSD_CODE_BASE |=> pm_region_out == MSD_REG_CODE)
    else $error("code base region wrong");
  a_region_hold: assert property (!pm_rd_in && !pm_wr_in |=> $stable(pm_region_out))
    else $error("region changed without a program access");

  // data space has no storage behind it
  a_ds_no_store: assert property (ds_wr_in && !rf_wr_in && !pm_wr_in
                                  |=> !ram_we_out && !ctrl_we_out && !flash_we_out)
    else $error("data space write reached a memory");
  a_ds_write_ack: assert property (ds_wr_in |=> ##1 ds_ack_out && ds_rdata_out == `MSD_UNDEF_BYTE)
    else $error("data space write answer wrong");

  c_ram_read: cover property (rf_rd_in && rf_addr_in == 12'h000 ##2 rf_ack_out);
  c_ctrl_write: cover property (rf_wr_in && rf_addr_in == 12'hf00 ##1 ctrl_we_out);
  c_info_read: cover property (pm_rd_in && pm_overlay && !pm_in_part ##1 info_re_out);
  c_part_read: cover property (pm_rd_in && pm_overlay && pm_in_part ##2 pm_ack_out);
  c_gap_write: cover property (rf_wr_in && {1'b0, rf_addr_in} >= RAM_SIZE && rf_addr_in < `MSD_CTRL_BASE ##1 rf_ack_out);
endmodule

// [msd_cfg.svh]
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH
// ----------------------------------------
// register file map
// ----------------------------------------
`define MSD_RF_AW 12
`define MSD_RAM_BASE 12'h000
`define MSD_RAM_SIZE 13'h0400
`define MSD_CTRL_BASE 12'hf00
`define MSD_CTRL_LAST 12'hfff
// ----------------------------------------
// program memory map
// ----------------------------------------
`define MSD_PM_AW 16
`define MSD_FLASH_SIZE 17'h02000
`define MSD_VEC_RESET 16'h0002
`define MSD_VEC_WDT 16'h0004
`define MSD_VEC_TRAP 16'h0006
`define MSD_VEC_IRQ 16'h0008
`define MSD_VEC_OSC 16'h0038
`define MSD_CODE_BASE 16'h003e
// ----------------------------------------
// information area overlay
// ----------------------------------------
`define MSD_INFO_SEL_BIT 7
`define MSD_INFO_BASE 16'hfe00
`define MSD_INFO_LAST 16'hff7f
`define MSD_PARTID_BASE 16'hfe40
`define MSD_PARTID_LAST 16'hfe53
`define MSD_PARTID_LEN 20
// ----------------------------------------
// fill values
// ----------------------------------------
`define MSD_UNIMP_BYTE 8'hff
`define MSD_UNDEF_BYTE 8'h00
`endif

// [msd_pkg.sv]
package msd_pkg;
  // program memory region of the last decoded address
  typedef enum logic [2:0] {
    MSD_REG_OPTION = 3'h0,
    MSD_REG_RESET = 3'h1,
    MSD_REG_WDT = 3'h3,
    MSD_REG_TRAP = 3'h2,
    MSD_REG_IRQ = 3'h6,
    MSD_REG_OSC = 3'h7,
    MSD_REG_CODE = 3'h5
  } msd_pm_region_e;
  // source of a register file read
  typedef enum logic [1:0] {
    MSD_RF_NONE = 2'h0,
    MSD_RF_RAM = 2'h1,
    MSD_RF_CTRL = 2'h3
  } msd_rf_src_e;
  // source of a program memory read
  typedef enum logic [1:0] {
    MSD_PM_FILL = 2'h0,
    MSD_PM_FLASH = 2'h1,
    MSD_PM_INFO = 2'h3,
    MSD_PM_PARTID = 2'h2
  } msd_pm_src_e;
endpackage

// [msd_mem_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// storage behind the decoder
// ----------------------------------------
module msd_mem_model (
  input wire logic clk_in,
  input wire logic [11:0] ram_a_in,
  input wire logic ram_re_in,
  input wire logic ram_we_in,
  input wire logic [7:0] ram_d_in,
  output logic [7:0] ram_q_out,
  input wire logic [7:0] ctl_a_in,
  input wire logic ctl_re_in,
  input wire logic ctl_we_in,
  input wire logic [7:0] ctl_d_in,
  output logic [7:0] ctl_q_out,
  input wire logic [15:0] fl_a_in,
  input wire logic fl_re_in,
  input wire logic fl_we_in,
  input wire logic [7:0] fl_d_in,
  output logic [7:0] fl_q_out,
  input wire logic [6:0] inf_a_in,
  input wire logic inf_re_in,
  output logic [7:0] inf_q_out,
  output logic [15:0] wr_cnt_out
);
  logic [7:0] ram [4096];
  logic [7:0] ctl [256];
  logic [7:0] fl [65536];
  // preload every store with an address pattern so no read is unknown
  initial begin
    wr_cnt_out = 16'h0000;
    for (int i = 0; i < 65536; i++) begin
      fl[i] = 8'(i) ^ 8'(i >> 8);
      ram[i % 4096] = 8'(i) ^ 8'h5a;
      ctl[i % 256] = 8'(i) + 8'h11;
    end
  end
  // writes land at the edge after the strobe; every write strobe is counted
  always @(posedge clk_in) begin
    if (ram_we_in) ram[ram_a_in] <= ram_d_in;
    if (ctl_we_in) ctl[ctl_a_in] <= ctl_d_in;
    if (fl_we_in) fl[fl_a_in] <= fl_d_in;
    wr_cnt_out <= wr_cnt_out + 16'(ram_we_in) + 16'(ctl_we_in) + 16'(fl_we_in);
  end
  // data only while selected, inverted otherwise so stale values never pass
  assign ram_q_out = ram_re_in ? ram[ram_a_in] : ~ram[ram_a_in];
  assign ctl_q_out = ctl_re_in ? ctl[ctl_a_in] : ~ctl[ctl_a_in];
  assign fl_q_out = fl_re_in ? fl[fl_a_in] : ~fl[fl_a_in];
  assign inf_q_out = inf_re_in ? {1'b1, inf_a_in} ^ 8'h33 : ~({1'b1, inf_a_in} ^ 8'h33);
endmodule

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import msd_pkg::*;
  localparam logic [159:0] PID = "MSDPART0FFFFFFFFFFFF";
  logic mclk_in, reset_n_in, rf_rd_in, rf_wr_in, pm_rd_in, pm_wr_in, ds_rd_in, ds_wr_in;
  logic rf_ack_out, pm_ack_out, ds_ack_out, ram_re_out, ram_we_out, ctrl_re_out, ctrl_we_out;
  logic flash_re_out, flash_we_out, info_re_out;
  logic [11:0] rf_addr_in, ram_addr_out;
  logic [15:0] pm_addr_in, flash_addr_out, wcnt;
  logic [7:0] rf_wdata_in, rf_rdata_out, pm_wdata_in, pm_rdata_out, ds_rdata_out, page_sel_in;
  logic [7:0] ram_wdata_out, ram_rdata_in, ctrl_addr_out, ctrl_wdata_out, ctrl_rdata_in;
  logic [7:0] flash_wdata_out, flash_rdata_in, info_rdata_in, q;
  logic [6:0] info_addr_out;
  msd_pm_region_e pm_region_out;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  // ----------------------------------------
  // design and storage model
  // ----------------------------------------
  msd_decoder #(.RAM_SIZE(13'h0200), .FLASH_SIZE(17'h00800), .PART_ID(PID)) DUT (
    .mclk_in, .reset_n_in, .rf_addr_in, .rf_rd_in, .rf_wr_in, .rf_wdata_in, .rf_rdata_out, .rf_ack_out,
    .pm_addr_in, .pm_rd_in, .pm_wr_in, .pm_wdata_in, .pm_rdata_out, .pm_ack_out, .pm_region_out,
    .ds_rd_in, .ds_wr_in, .ds_rdata_out, .ds_ack_out, .page_sel_in, .ram_addr_out, .ram_re_out,
    .ram_we_out, .ram_wdata_out, .ram_rdata_in, .ctrl_addr_out, .ctrl_re_out, .ctrl_we_out,
    .ctrl_wdata_out, .ctrl_rdata_in, .flash_addr_out, .flash_re_out, .flash_we_out, .flash_wdata_out,
    .flash_rdata_in, .info_addr_out, .info_re_out, .info_rdata_in);
  msd_mem_model MEM (.clk_in(mclk_in), .ram_a_in(ram_addr_out), .ram_re_in(ram_re_out),
    .ram_we_in(ram_we_out), .ram_d_in(ram_wdata_out), .ram_q_out(ram_rdata_in), .ctl_a_in(ctrl_addr_out),
    .ctl_re_in(ctrl_re_out), .ctl_we_in(ctrl_we_out), .ctl_d_in(ctrl_wdata_out), .ctl_q_out(ctrl_rdata_in),
    .fl_a_in(flash_addr_out), .fl_re_in(flash_re_out), .fl_we_in(flash_we_out), .fl_d_in(flash_wdata_out),
    .fl_q_out(flash_rdata_in), .inf_a_in(info_addr_out), .inf_re_in(info_re_out),
    .inf_q_out(info_rdata_in), .wr_cnt_out(wcnt));
  // clock and hang guard
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one access on bus k (0 register file, 1 program, 2 data); answer stands after the edge following the take
  task automatic acc(input int k, input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge mclk_in);
    rf_addr_in <= a[11:0];
    pm_addr_in <= a;
    rf_wdata_in <= d;
    pm_wdata_in <= d;
    {rf_rd_in, rf_wr_in} <= k == 0 ? {!w, w} : 2'b00;
    {pm_rd_in, pm_wr_in} <= k == 1 ? {!w, w} : 2'b00;
    {ds_rd_in, ds_wr_in} <= k == 2 ? {!w, w} : 2'b00;
    @(posedge mclk_in);
    {rf_rd_in, rf_wr_in, pm_rd_in, pm_wr_in, ds_rd_in, ds_wr_in} <= 6'h00;
    @(posedge mclk_in);
    #1;
    chk(k == 0 ? rf_ack_out : k == 1 ? pm_ack_out : ds_ack_out, 16'h0001);
    r = k == 0 ? rf_rdata_out : k == 1 ? pm_rdata_out : ds_rdata_out;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_gap;
    logic [15:0] w0;
    w0 = wcnt;
    acc(0, 1, 16'h0200, 8'h77, q);
    acc(0, 1, 16'h0eff, 8'h77, q);
    chk(wcnt, w0);
    acc(0, 0, 16'h0200, 8'h00, q);
    chk(q, 8'h00);
  endtask
  task t_ram;
    acc(0, 1, 16'h01ff, 8'ha5, q);
    acc(0, 0, 16'h01ff, 8'h00, q);
    chk(q, 8'ha5);
    acc(0, 0, 16'h0000, 8'h00, q);
    chk(q, 8'h5a);
  endtask
  task t_ctrl;
    acc(0, 1, 16'h0f05, 8'h3c, q);
    acc(0, 0, 16'h0f05, 8'h00, q);
    chk(q, 8'h3c);
    acc(0, 0, 16'h0fff, 8'h00, q);
    chk(q, 8'h10);
  endtask
  task automatic t_flash;
    logic [15:0] w0;
    acc(1, 1, 16'h07ff, 8'h11, q);
    acc(1, 0, 16'h07ff, 8'h00, q);
    chk(q, 8'h11);
    w0 = wcnt;
    acc(1, 1, 16'h0800, 8'h22, q);
    chk(wcnt, w0);
    acc(1, 0, 16'h0800, 8'h00, q);
    chk(q, 8'hff);
  endtask
  // vector table edges, each region's first and last byte where cheap
  task t_region;
    logic [15:0] a [9] = '{16'h0001, 16'h0002, 16'h0005, 16'h0006, 16'h0008, 16'h0037, 16'h0038,
                           16'h003d, 16'h003e};
    msd_pm_region_e e [9] = '{MSD_REG_OPTION, MSD_REG_RESET, MSD_REG_WDT, MSD_REG_TRAP, MSD_REG_IRQ,
                              MSD_REG_IRQ, MSD_REG_OSC, MSD_REG_OSC, MSD_REG_CODE};
    for (int i = 0; i < 9; i++) begin
      acc(1, 0, a[i], 8'h00, q);
      chk(16'(pm_region_out), 16'(e[i]));
    end
  endtask
  task automatic t_info;
    logic [15:0] w0;
    @(posedge mclk_in) page_sel_in <= 8'h80;
    acc(1, 0, 16'hfe41, 8'h00, q);
    chk(q, PID[151:144]);
    acc(1, 0, 16'hfe60, 8'h00, q);
    chk(q, 8'he0 ^ 8'h33);
    acc(1, 0, 16'hff7f, 8'h00, q);
    chk(q, 8'hff ^ 8'h33);
    w0 = wcnt;
    acc(1, 1, 16'hfe60, 8'h55, q);
    chk(wcnt, w0);
    @(posedge mclk_in) page_sel_in <= 8'h7f;
    acc(1, 0, 16'hfe60, 8'h00, q);
    chk(q, 8'hff);
    acc(1, 0, 16'hfe41, 8'h00, q);
    chk(q, 8'hff);
  endtask
  task t_ds;
    acc(2, 1, 16'h0000, 8'h99, q);
    acc(2, 0, 16'h0000, 8'h00, q);
    chk(q, 8'h00);
  endtask
  // main sequence
  initial begin
    {reset_n_in, rf_rd_in, rf_wr_in, pm_rd_in, pm_wr_in, ds_rd_in, ds_wr_in} = 7'h00;
    rf_addr_in = 12'h000;
    pm_addr_in = 16'h0000;
    {rf_wdata_in, pm_wdata_in, page_sel_in} = 24'h000000;
    repeat (16) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    chk(16'(pm_region_out), 16'(MSD_REG_OPTION));
    t_gap;
    t_ram;
    t_ctrl;
    t_flash;
    t_region;
    t_info;
    t_ds;
    tally_and_finish;
  end
endmodule
